// ==== hw/counter_array_watchdog.sv ====
// Counter array control, 16-bit counter and module 4 watchdog, APB slave.
// Assumes one 40 MHz clock; match inputs are same-clock one-cycle pulses.
// Function
// [R01] Low byte overflow at high-byte match resets
// [R02] Writing 1 to module-4 flag forces reset
// [R03] Software configures in documented order
// [R04] Clock select and idle frozen while enabled
// [R05] Enable bit or lock bit enables watchdog
// [R06] Lock holds enable until reset
// [R07] Reset: enabled, divide by 12, zeroed
// [R08] Default timeout 256 counter clocks, 3072 cycles
// [R09] Overflow flag set on wrap, sticky
// [R10] Enabled overflow flag requests interrupt
// [R11] Run bit 6 stops or runs counter
// [R12] Control bit 5 reads zero
// [R13] Event flags sticky, request when enabled
// [R14] Update write loads high byte plus offset
// [R15] Timeout is offset pages plus remainder
// [R16] Enabled: counter forced on, writes blocked
// [R17] Clock select picks counter timebase
// [R18] One-cycle reset pulse clears whole array
module counter_array_watchdog
  import watchdog_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_idle,
  input  wire logic        timer0_overflow,
  input  wire logic [4:0]  module_match,
  input  wire logic        external_count_input,
  input  wire logic        external_clock,
  output logic             counter_irq,
  output logic             watchdog_reset
);
  counter_tick_if tb ();

  logic [15:0] cnt_r,     cnt_nxt;
  logic        ovf_r,     ovf_nxt;
  logic        run_r,     run_nxt;
  logic [4:0]  evt_r,     evt_nxt;
  logic        idle_r,    idle_nxt;
  logic        wden_r,    wden_nxt;
  logic        lock_r,    lock_nxt;
  logic [2:0]  sel_r,     sel_nxt;
  logic        ovfie_r,   ovfie_nxt;
  logic [7:0]  offset_r,  offset_nxt;
  logic [7:0]  update_r,  update_nxt;
  logic [4:0]  ien_r,     ien_nxt;
  logic [31:0] prdata_r,  prdata_nxt;
  logic        pready_r,  pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        irq_r,     irq_nxt;
  logic        wdrst_r,   wdrst_nxt;
  logic        wd_en;
  logic        advance;
  logic        low_ovf;
  logic        wrap;
  logic        wd_fire;
  logic        wr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  counter_timebase u_timebase (
    .pclk                 (pclk),
    .presetn              (presetn),
    .clk_en               (clk_en),
    .timer0_overflow      (timer0_overflow),
    .external_count_input (external_count_input),
    .external_clock       (external_clock),
    .tb                   (tb)
  );

  assign tb.clk_sel = sel_r; // [R17]
  assign wd_en      = wden_r || lock_r; // [R05] [R06]
  assign wr         = psel && penable && pwrite && pready_r;
  // Counter forced on while the watchdog is enabled
  assign advance    = (run_r || wd_en) && tb.tick && !(cpu_idle && idle_r); // [R11] [R16]
  assign low_ovf    = advance && (cnt_r[7:0] == 8'hff);
  assign wrap       = advance && (cnt_r == 16'hffff);
  assign wd_fire    = wd_en && ((low_ovf && (update_r == cnt_r[15:8])) // [R01] [R15]
                      || (wr && hit(paddr, ADDR_CTRL) && pwdata[CTRL_EVT_MSB])); // [R02]

  always_comb begin
    cnt_nxt     = cnt_r;
    ovf_nxt     = ovf_r;
    run_nxt     = run_r;
    evt_nxt     = evt_r;
    idle_nxt    = idle_r;
    wden_nxt    = wden_r;
    lock_nxt    = lock_r;
    sel_nxt     = sel_r;
    ovfie_nxt   = ovfie_r;
    offset_nxt  = offset_r;
    update_nxt  = update_r;
    ien_nxt     = ien_r;
    if (advance) begin
      cnt_nxt = cnt_r + 16'd1;
    end
    if (wr && hit(paddr, ADDR_CTRL)) begin
      ovf_nxt = pwdata[CTRL_OVF];
      run_nxt = pwdata[CTRL_RUN];
      evt_nxt = pwdata[CTRL_EVT_MSB:0];
    end
    if (wr && hit(paddr, ADDR_MODE)) begin
      wden_nxt = pwdata[MODE_ENABLE];
      lock_nxt = lock_r || pwdata[MODE_LOCK]; // [R06]
      if (!wd_en) begin // [R04]
        idle_nxt  = pwdata[MODE_IDLE];
        sel_nxt   = pwdata[MODE_SEL_LSB +: 3];
        ovfie_nxt = pwdata[MODE_OVF_IE];
      end
    end
    if (wr && !wd_en && hit(paddr, ADDR_CNT_LO)) begin // [R16]
      cnt_nxt[7:0] = pwdata[7:0];
    end
    if (wr && !wd_en && hit(paddr, ADDR_CNT_HI)) begin // [R16]
      cnt_nxt[15:8] = pwdata[7:0];
    end
    if (wr && hit(paddr, ADDR_OFFSET)) begin
      offset_nxt = pwdata[7:0];
    end
    if (wr && hit(paddr, ADDR_UPDATE)) begin
      update_nxt = cnt_r[15:8] + offset_r; // [R14]
    end
    if (wr && hit(paddr, ADDR_IEN)) begin
      ien_nxt = pwdata[4:0];
    end
    // Hardware set wins over a same-cycle software clear
    if (wrap) begin
      ovf_nxt = 1'b1; // [R09]
    end
    evt_nxt   = evt_nxt | module_match; // [R13]
    irq_nxt   = (ovf_r && ovfie_r) || |(evt_r & ien_r); // [R10] [R13]
    wdrst_nxt = wd_fire; // [R18]
    if (wd_fire) begin // [R07] [R18]
      cnt_nxt    = CNT_RST;
      ovf_nxt    = CTRL_RST[CTRL_OVF];
      run_nxt    = CTRL_RST[CTRL_RUN];
      evt_nxt    = CTRL_RST[CTRL_EVT_MSB:0];
      idle_nxt   = MODE_RST[MODE_IDLE];
      wden_nxt   = MODE_RST[MODE_ENABLE];
      lock_nxt   = MODE_RST[MODE_LOCK];
      sel_nxt    = MODE_RST[MODE_SEL_LSB +: 3];
      ovfie_nxt  = MODE_RST[MODE_OVF_IE];
      offset_nxt = OFFSET_RST;
      update_nxt = UPDATE_RST;
      ien_nxt    = IEN_RST;
      irq_nxt    = 1'b0;
    end
  end

  // Read data captured in the setup cycle, answered in the first access cycle
  always_comb begin
    pready_nxt  = psel && !penable;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        ADDR_CTRL:   prdata_nxt[7:0] = {ovf_r, run_r, 1'b0, evt_r}; // [R12]
        ADDR_MODE:   prdata_nxt[7:0] = {idle_r, wden_r, lock_r, 1'b0, sel_r, ovfie_r};
        ADDR_CNT_LO: prdata_nxt[7:0] = cnt_r[7:0];
        ADDR_CNT_HI: prdata_nxt[7:0] = cnt_r[15:8];
        ADDR_OFFSET: prdata_nxt[7:0] = offset_r;
        ADDR_UPDATE: prdata_nxt[7:0] = update_r;
        ADDR_IEN:    prdata_nxt[4:0] = ien_r;
        default:     pslverr_nxt     = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= CNT_RST;
      ovf_r     <= CTRL_RST[CTRL_OVF];
      run_r     <= CTRL_RST[CTRL_RUN];
      evt_r     <= CTRL_RST[CTRL_EVT_MSB:0];
      idle_r    <= MODE_RST[MODE_IDLE];
      wden_r    <= MODE_RST[MODE_ENABLE]; // [R07]
      lock_r    <= MODE_RST[MODE_LOCK];
      sel_r     <= MODE_RST[MODE_SEL_LSB +: 3];
      ovfie_r   <= MODE_RST[MODE_OVF_IE];
      offset_r  <= OFFSET_RST;
      update_r  <= UPDATE_RST; // [R08]
      ien_r     <= IEN_RST;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r     <= 1'b0;
      wdrst_r   <= 1'b0;
    end else if (clk_en) begin
      cnt_r     <= cnt_nxt;
      ovf_r     <= ovf_nxt;
      run_r     <= run_nxt;
      evt_r     <= evt_nxt;
      idle_r    <= idle_nxt;
      wden_r    <= wden_nxt;
      lock_r    <= lock_nxt;
      sel_r     <= sel_nxt;
      ovfie_r   <= ovfie_nxt;
      offset_r  <= offset_nxt;
      update_r  <= update_nxt;
      ien_r     <= ien_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r     <= irq_nxt;
      wdrst_r   <= wdrst_nxt;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign counter_irq    = irq_r;
  assign watchdog_reset = wdrst_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fire;
    clk_en && wd_fire;
  endsequence

  sequence s_pulse_then_defaults;
    watchdog_reset && cnt_r == CNT_RST && wden_r && !lock_r && sel_r == SEL_DIV12
      ##1 !watchdog_reset;
  endsequence

  a_match_overflow_rst: assert property ( // [R01]
    (clk_en && wd_en && low_ovf && update_r == cnt_r[15:8]) |=> watchdog_reset)
    else $error("match with low byte overflow did not reset");

  a_flag_write_rst: assert property ( // [R02]
    (clk_en && wd_en && wr && hit(paddr, ADDR_CTRL) && pwdata[CTRL_EVT_MSB])
      |=> watchdog_reset)
    else $error("module 4 flag write did not force reset");

  a_reset_pulse_shape: assert property (s_fire |=> s_pulse_then_defaults) // [R18]
    else $error("watchdog reset pulse or defaults wrong");

  a_select_frozen: assert property ( // [R04]
    (clk_en && wd_en && !wd_fire) |=> $stable(sel_r) && $stable(idle_r))
    else $error("clock select or idle changed while enabled");

  a_lock_sticky: assert property ( // [R06]
    (clk_en && lock_r && !wd_fire) |=> lock_r && wd_en)
    else $error("lock or enable dropped before reset");

  a_forced_count: assert property ( // [R16]
    (clk_en && wd_en && tb.tick && !(cpu_idle && idle_r) && !wd_fire)
      |=> cnt_r == $past(cnt_r) + 16'd1)
    else $error("counter not forced on while enabled");

  a_update_load: assert property ( // [R14]
    (clk_en && wr && hit(paddr, ADDR_UPDATE) && !wd_fire)
      |=> update_r == $past(cnt_r[15:8]) + $past(offset_r))
    else $error("update byte not loaded with high byte plus offset");

  a_wrap_sets_flag: assert property ((clk_en && wrap && !wd_fire) |=> ovf_r) // [R09]
    else $error("overflow flag not set on wrap");

  a_stopped_counter: assert property ( // [R11]
    (clk_en && !run_r && !wd_en && !wr) |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  a_overflow_irq: assert property ( // [R10]
    (clk_en && ovf_r && ovfie_r && !wd_fire) |=> counter_irq)
    else $error("overflow interrupt request missing");

  a_unused_bit_zero: assert property ( // [R12]
    (pready && !pslverr && $past(paddr) == ADDR_CTRL) |-> prdata[5] == 1'b0)
    else $error("control bit 5 read as one");

  a_event_irq: assert property ( // [R13]
    (clk_en && |(evt_r & ien_r) && !wd_fire) |=> counter_irq)
    else $error("event flag interrupt request missing");

  a_event_sticky: assert property ( // [R13]
    (clk_en && |module_match && !wd_fire)
      |=> (evt_r & $past(module_match)) == $past(module_match))
    else $error("event flag not set by a match");

  a_enable_sets: assert property ( // [R05]
    (clk_en && wr && hit(paddr, ADDR_MODE) && !wd_fire
      && (pwdata[MODE_ENABLE] || pwdata[MODE_LOCK])) |=> wd_en)
    else $error("enable or lock write did not enable watchdog");

  a_unlocked_disable: assert property ( // [R06]
    (clk_en && wr && hit(paddr, ADDR_MODE) && !wd_fire && !lock_r
      && !pwdata[MODE_ENABLE] && !pwdata[MODE_LOCK]) |=> !wd_en)
    else $error("clearing enable did not disable watchdog");
endmodule

// ==== common/watchdog_pkg.sv ====
// Shared constants of the counter array watchdog: offsets, fields, resets.
// Assumes one system clock and a 32-bit APB register bus.
package watchdog_pkg;
  localparam logic [7:0]  ADDR_CTRL    = 8'hd8;
  localparam logic [7:0]  ADDR_MODE    = 8'hdc;
  localparam logic [7:0]  ADDR_CNT_LO  = 8'he0;
  localparam logic [7:0]  ADDR_CNT_HI  = 8'he4;
  localparam logic [7:0]  ADDR_OFFSET  = 8'he8;
  localparam logic [7:0]  ADDR_UPDATE  = 8'hec;
  localparam logic [7:0]  ADDR_IEN     = 8'hf0;

  localparam int          CTRL_OVF     = 7;
  localparam int          CTRL_RUN     = 6;
  localparam int          CTRL_EVT_MSB = 4;
  localparam int          MODE_IDLE    = 7;
  localparam int          MODE_ENABLE  = 6;
  localparam int          MODE_LOCK    = 5;
  localparam int          MODE_SEL_LSB = 1;
  localparam int          MODE_OVF_IE  = 0;

  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  MODE_RST     = 8'h40;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [7:0]  OFFSET_RST   = 8'h00;
  localparam logic [7:0]  UPDATE_RST   = 8'h00;
  localparam logic [4:0]  IEN_RST      = 5'h00;

  localparam logic [2:0]  SEL_DIV12    = 3'b000;
  localparam logic [2:0]  SEL_DIV4     = 3'b001;
  localparam logic [2:0]  SEL_TIMER0   = 3'b010;
  localparam logic [2:0]  SEL_EXT_FALL = 3'b011;
  localparam logic [2:0]  SEL_SYSCLK   = 3'b100;
  localparam logic [2:0]  SEL_EXT_DIV8 = 3'b101;

  localparam logic [3:0]  DIV12_LAST   = 4'd11;
  localparam logic [3:0]  DIV4_LAST    = 4'd3;
  localparam logic [2:0]  EXT_DIV_LAST = 3'd7;
endpackage

// ==== common/counter_tick_if.sv ====
// Carries the timebase selection and the resulting count tick.
// Assumes both ends run on the system clock.
interface counter_tick_if;
  logic [2:0] clk_sel;
  logic       tick;
  modport src  (input clk_sel, output tick);
  modport sink (output clk_sel, input tick);
endinterface

// ==== hw/counter_timebase.sv ====
// Timebase for the counter: prescalers, timer 0 overflow and external inputs.
// Assumes pin inputs are asynchronous; timer0_overflow is a same-clock pulse.
module counter_timebase
  import watchdog_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       timer0_overflow,
  input  wire logic       external_count_input,
  input  wire logic       external_clock,
  counter_tick_if.src     tb
);
  logic [3:0] div_r,  div_nxt;
  logic [2:0] ext_r,  ext_nxt;
  logic [2:0] eci_r,  eci_nxt;
  logic [2:0] eck_r,  eck_nxt;
  logic       tick_r, tick_nxt;

  always_comb begin
    div_nxt  = div_r + 4'd1;
    ext_nxt  = ext_r;
    eci_nxt  = {eci_r[1:0], external_count_input};
    eck_nxt  = {eck_r[1:0], external_clock};
    tick_nxt = 1'b0;
    // Rising edges of the synchronised external clock, counted by eight
    if (eck_r[1] && !eck_r[2]) begin
      ext_nxt = ext_r + 3'd1;
    end
    case (tb.clk_sel) // [R17]
      SEL_DIV12: begin
        tick_nxt = (div_r >= DIV12_LAST);
        if (div_r >= DIV12_LAST) begin
          div_nxt = 4'd0;
        end
      end
      SEL_DIV4: begin
        tick_nxt = (div_r >= DIV4_LAST);
        if (div_r >= DIV4_LAST) begin
          div_nxt = 4'd0;
        end
      end
      SEL_TIMER0:   tick_nxt = timer0_overflow;
      SEL_EXT_FALL: tick_nxt = eci_r[2] && !eci_r[1];
      SEL_SYSCLK:   tick_nxt = 1'b1;
      SEL_EXT_DIV8: tick_nxt = eck_r[1] && !eck_r[2] && (ext_r == EXT_DIV_LAST);
      default:      tick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r  <= 4'd0;
      ext_r  <= 3'd0;
      eci_r  <= 3'b111;
      eck_r  <= 3'b000;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      div_r  <= div_nxt;
      ext_r  <= ext_nxt;
      eci_r  <= eci_nxt;
      eck_r  <= eck_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tb.tick = tick_r;
endmodule

// ==== testbench/test_counter_array_watchdog.sv ====
// Directed testbench of the counter array watchdog over APB.
// Assumes an APB slave that answers with pready and a one-cycle reset pulse.
module test_counter_array_watchdog
  import watchdog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  module_match;
  logic        timer0_overflow;
  logic        external_count_input;
  logic        counter_irq;
  logic        watchdog_reset;
  int          errors;
  int          checks;
  int          cyc;
  int          pulses;
  int          t0;
  int          p0;
  logic [7:0]  q;
  logic [7:0]  q2;
  logic        err;

  counter_array_watchdog dut (
    .pclk                 (pclk),
    .presetn              (presetn),
    .clk_en               (1'b1),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .cpu_idle             (1'b0),
    .timer0_overflow      (timer0_overflow),
    .module_match         (module_match),
    .external_count_input (external_count_input),
    .external_clock       (1'b0),
    .counter_irq          (counter_irq),
    .watchdog_reset       (watchdog_reset)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Cycle count, watchdog pulse count and hang guard
  always @(negedge pclk) begin
    cyc <= cyc + 1;
    if (watchdog_reset === 1'b1) pulses <= pulses + 1;
    if (cyc > 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is sampled high at a rising edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(q, exp);
  endtask

  // Waits for a watchdog pulse; it must land lo..hi cycles after start
  task automatic wait_pulse(input int start, input int lo, input int hi);
    int p;
    p = pulses;
    while (pulses == p && cyc - start <= hi) @(negedge pclk);
    check({7'h00, pulses != p && cyc - start >= lo}, 8'h01);
  endtask

  initial begin
    errors = 0;
    checks = 0;
    cyc = 0;
    pulses = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    module_match = 5'h00;
    timer0_overflow = 1'b0;
    external_count_input = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    rd_chk(ADDR_CNT_LO, 8'h00);
    rd_chk(ADDR_CTRL, CTRL_RST);
    rd_chk(ADDR_MODE, MODE_RST);
    rd_chk(ADDR_OFFSET, OFFSET_RST);
    wait_pulse(t0, 3060, 3090);
    rd_chk(ADDR_MODE, MODE_RST);
    wr(ADDR_MODE, 8'h00);
    for (int s = 0; s < 6; s++) begin
      wr(ADDR_MODE, 8'(s << 1));
      rd_chk(ADDR_MODE, 8'(s << 1));
    end
    apb(1'b0, 8'hfc, 8'h00);
    check({7'h00, err}, 8'h01);
    // Timer 0 pulses, then falling count-input edges, drive the counter
    wr(ADDR_MODE, 8'h04);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    repeat (3) begin
      @(posedge pclk);
      timer0_overflow <= 1'b1;
      @(posedge pclk);
      timer0_overflow <= 1'b0;
    end
    wr(ADDR_MODE, 8'h06);
    repeat (2) begin
      @(posedge pclk);
      external_count_input <= 1'b0;
      repeat (4) @(posedge pclk);
      external_count_input <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    wr(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_CNT_LO, 8'h05);
    // Flag 4 set by software while disabled gives no reset
    p0 = pulses;
    wr(ADDR_CTRL, 8'h30);
    repeat (8) @(posedge pclk);
    check(8'(pulses - p0), 8'h00);
    rd_chk(ADDR_CTRL, 8'h10);
    wr(ADDR_CNT_LO, 8'h55);
    rd_chk(ADDR_CNT_LO, 8'h55);
    // Wrap of the counter sets the sticky overflow flag
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_CNT_LO, 8'hf0);
    wr(ADDR_CTRL, 8'h40);
    for (int n = 0; n < 100 && counter_irq !== 1'b1; n++) @(posedge pclk);
    check({7'h00, counter_irq}, 8'h01);
    rd_chk(ADDR_CTRL, 8'hc0);
    wr(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_CTRL, 8'h00);
    check({7'h00, counter_irq}, 8'h00);
    wr(ADDR_IEN, 8'h04);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      module_match <= 5'(1 << i);
      @(posedge pclk);
      module_match <= 5'h00;
    end
    rd_chk(ADDR_CTRL, 8'h0f);
    check({7'h00, counter_irq}, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    // Configure in order, then offset 1 gives about 512 ticks
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_OFFSET, 8'h01);
    wr(ADDR_MODE, 8'h48);
    wr(ADDR_UPDATE, 8'h00);
    t0 = cyc;
    wr(ADDR_MODE, 8'hc2);
    rd_chk(ADDR_MODE, 8'h48);
    wr(ADDR_CNT_HI, 8'h80);
    apb(1'b0, ADDR_CNT_LO, 8'h00);
    q2 = q;
    apb(1'b0, ADDR_CNT_HI, 8'h00);
    check({7'h00, q != 8'h80}, 8'h01);
    apb(1'b0, ADDR_CNT_LO, 8'h00);
    check({7'h00, q != q2}, 8'h01);
    wait_pulse(t0, 400, 530);
    // Lock alone enables and cannot be cleared
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_MODE, 8'h20);
    wr(ADDR_MODE, 8'h00);
    rd_chk(ADDR_MODE, 8'h20);
    wr(ADDR_CTRL, 8'h10);
    wait_pulse(cyc, 0, 4);
    rd_chk(ADDR_MODE, MODE_RST);
    give_verdict();
  end
endmodule
